/* common/vecirq_pkg.sv */
// Contract
// - Two 4-bit read/write priority thresholds, one per target, in bits 3:0.
// - A pending enabled request reaches a target only above its threshold.
// - Threshold bits 31:4 and vector bits 10:9 read zero; software leaves them.
// - Vector register reports highest-priority enabled pending request when read.
// - With no eligible request the vector index field reads zero.
// - Vector index in bits 8:3 is the binary request number, from 1.
// - Vector bits 31:11 hold a writable table base, 2048-byte aligned.
// - Vector bits 2:0 read zero, so the value is base plus index times eight.
// - Vector value points straight at a 64-bit table entry.
// - Low summary sets bit n while request n pends, n 1..31; bit 0 zero.
// - High summary sets bit k while request 32+k pends, k 0..24.
// - A read-only features register describes the configuration.
// - Features: targets-1 in 21:16, priorities-1 in 15:8, 7:0 reads 0x3F for the 56 requests.
// - Each request has its own control register from offset 0x404.
package vecirq_pkg;

  localparam int          NREQ          = 56;
  localparam int          NTGT          = 2;
  localparam logic [31:0] OFF_THR0      = 32'hFFFF_F000;
  localparam logic [31:0] OFF_THR1      = 32'hFFFF_F004;
  localparam logic [31:0] OFF_VEC0      = 32'hFFFF_F100;
  localparam logic [31:0] OFF_VEC1      = 32'hFFFF_F104;
  localparam logic [31:0] OFF_PEND_LO   = 32'hFFFF_F200;
  localparam logic [31:0] OFF_PEND_HI   = 32'hFFFF_F204;
  localparam logic [31:0] OFF_FEATURES  = 32'hFFFF_F300;
  localparam logic [31:0] OFF_IRQ_STAT  = 32'hFFFF_F310;
  localparam logic [31:0] OFF_IRQ_MASK  = 32'hFFFF_F314;
  localparam logic [19:0] BLOCK_PAGE    = 20'hFFFFF;
  localparam logic [3:0]  CTRL_PAGE     = 4'h4;
  localparam logic [31:0] FEATURES_VAL  = 32'h0001_0F3F;
  localparam int          CTRL_TGT_BIT  = 8;
  localparam int          CTRL_EN_BIT   = 16;
  localparam int          CTRL_PEND_BIT = 31;
  localparam logic [3:0]  THR_RESET     = 4'h0;
  localparam logic [20:0] BASE_RESET    = 21'h000000;
  localparam logic [1:0]  MASK_RESET    = 2'h0;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vecirq_bus_t;

  typedef struct packed {
    logic [3:0] prio;
    logic       target;
    logic       enable;
  } vecirq_ctrl_t;

  typedef struct packed {
    logic [NTGT-1:0][3:0]  thr;
    logic [NTGT-1:0][20:0] base;
    vecirq_ctrl_t [NREQ:1] ctrl;
    logic [31:0]           rdata;
    logic [NTGT-1:0]       tgt_req;
    logic [NTGT-1:0]       status;
    logic [NTGT-1:0]       mask;
    logic                  irq;
  } vecirq_state_t;

endpackage

/* design/vecirq_top.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module vecirq_top
  import vecirq_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire vecirq_bus_t  bus,
  input  wire logic [NREQ:1] req_in,
  output logic [31:0]       rdata,
  output logic              irq_core,
  output logic              wake_pm,
  output logic              irq
);

  // ----------------------------------------------------------------
  // State and eligibility
  // ----------------------------------------------------------------
  vecirq_state_t          st;
  vecirq_state_t          next_st;
  logic [NTGT-1:0][NREQ:1] elig;
  logic [NTGT-1:0][NREQ:1] beaten;
  logic [NTGT-1:0][5:0]   vidx;
  logic [NTGT-1:0][3:0]   vprio;
  logic                   ctrl_hit;
  logic [5:0]             ctrl_n;

  genvar n;
  generate
    for (n = 1; n <= NREQ; n++) begin : g_req
      // Eligible: pending, enabled, routed here, strictly above threshold
      assign elig[0][n] = req_in[n] & st.ctrl[n].enable & ~st.ctrl[n].target &
                          (st.ctrl[n].prio > st.thr[0]);
      assign elig[1][n] = req_in[n] & st.ctrl[n].enable & st.ctrl[n].target &
                          (st.ctrl[n].prio > st.thr[1]);
      // Checking aid: an eligible request that should have won
      assign beaten[0][n] = elig[0][n] & ((st.ctrl[n].prio > vprio[0]) |
                            ((st.ctrl[n].prio == vprio[0]) & (6'(n) < vidx[0])));
      assign beaten[1][n] = elig[1][n] & ((st.ctrl[n].prio > vprio[1]) |
                            ((st.ctrl[n].prio == vprio[1]) & (6'(n) < vidx[1])));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Winner selection per target
  // ----------------------------------------------------------------
  always_comb begin
    for (int t = 0; t < NTGT; t++) begin
      vidx[t]  = 6'h00;
      vprio[t] = 4'h0;
      for (int r = 1; r <= NREQ; r++) begin
        // Strictly greater keeps the lowest number on a tie
        if (elig[t][r] && (vidx[t] == 6'h00 || st.ctrl[r].prio > vprio[t])) begin
          vidx[t]  = 6'(r);
          vprio[t] = st.ctrl[r].prio;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register decode and next state
  // ----------------------------------------------------------------
  assign ctrl_n   = bus.addr[7:2];
  assign ctrl_hit = (bus.addr[31:12] == BLOCK_PAGE) && (bus.addr[11:8] == CTRL_PAGE) &&
                    (bus.addr[1:0] == 2'h0) && (ctrl_n >= 6'h01) &&
                    (ctrl_n <= 6'(NREQ));

  always_comb begin
    next_st       = st;
    next_st.rdata = 32'h0000_0000;
    // Target request lines follow the winner every cycle
    for (int t = 0; t < NTGT; t++) begin
      next_st.tgt_req[t] = (vidx[t] != 6'h00);
    end
    if (bus.wr) begin
      case (bus.addr)
        OFF_THR0:     next_st.thr[0] = bus.wdata[3:0];
        OFF_THR1:     next_st.thr[1] = bus.wdata[3:0];
        OFF_VEC0:     next_st.base[0] = bus.wdata[31:11];
        OFF_VEC1:     next_st.base[1] = bus.wdata[31:11];
        OFF_IRQ_MASK: next_st.mask = bus.wdata[1:0];
        OFF_IRQ_STAT: next_st.status = st.status & ~bus.wdata[1:0];
        default: begin
          if (ctrl_hit) begin
            next_st.ctrl[ctrl_n].prio   = bus.wdata[3:0];
            next_st.ctrl[ctrl_n].target = bus.wdata[CTRL_TGT_BIT];
            next_st.ctrl[ctrl_n].enable = bus.wdata[CTRL_EN_BIT];
          end
        end
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        OFF_THR0:     next_st.rdata = {28'h0000000, st.thr[0]};
        OFF_THR1:     next_st.rdata = {28'h0000000, st.thr[1]};
        OFF_VEC0:     next_st.rdata = {st.base[0], 2'h0, vidx[0], 3'h0};
        OFF_VEC1:     next_st.rdata = {st.base[1], 2'h0, vidx[1], 3'h0};
        OFF_PEND_LO:  next_st.rdata = {req_in[31:1], 1'b0};
        OFF_PEND_HI:  next_st.rdata = {7'h00, req_in[56:32]};
        OFF_FEATURES: next_st.rdata = FEATURES_VAL;
        OFF_IRQ_STAT: next_st.rdata = {30'h00000000, st.status};
        OFF_IRQ_MASK: next_st.rdata = {30'h00000000, st.mask};
        default: begin
          if (ctrl_hit) begin
            next_st.rdata[3:0]           = st.ctrl[ctrl_n].prio;
            next_st.rdata[CTRL_TGT_BIT]  = st.ctrl[ctrl_n].target;
            next_st.rdata[CTRL_EN_BIT]   = st.ctrl[ctrl_n].enable;
            next_st.rdata[CTRL_PEND_BIT] = req_in[ctrl_n];
          end
        end
      endcase
    end
    // Rising target request sets sticky status; set beats a same-cycle clear
    for (int t = 0; t < NTGT; t++) begin
      if (next_st.tgt_req[t] && !st.tgt_req[t]) begin
        next_st.status[t] = 1'b1;
      end
    end
    next_st.irq = |(st.status & st.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st         <= '0;
      st.thr[0]  <= THR_RESET;
      st.thr[1]  <= THR_RESET;
      st.base[0] <= BASE_RESET;
      st.base[1] <= BASE_RESET;
      st.mask    <= MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata    = st.rdata;
  assign irq_core = st.tgt_req[0];
  assign wake_pm  = st.tgt_req[1];
  assign irq      = st.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_rd_thr0;
    bus.rd && bus.addr == OFF_THR0;
  endsequence

  sequence s_rd_vec0;
    bus.rd && bus.addr == OFF_VEC0;
  endsequence

  sequence s_rd_vec1;
    bus.rd && bus.addr == OFF_VEC1;
  endsequence

  sequence s_wr_thr0;
    bus.wr && bus.addr == OFF_THR0;
  endsequence

  a_thr_write_read: assert property (s_wr_thr0 ##1 (s_rd_thr0 and !bus.wr) |=>
      rdata == {28'h0000000, $past(bus.wdata[3:0], 2)})
    else $error("threshold readback wrong");

  a_thr_reserved: assert property (s_rd_thr0 |=> rdata[31:4] == 28'h0000000)
    else $error("threshold reserved bits not zero");

  a_vec_fields: assert property ((s_rd_vec0 or s_rd_vec1) |=>
      rdata[2:0] == 3'h0 && rdata[10:9] == 2'h0)
    else $error("vector low bits not zero");

  a_vec_base: assert property (s_rd_vec1 |=> rdata[31:11] == $past(st.base[1]))
    else $error("vector base wrong");

  a_vec_empty: assert property (s_rd_vec0 ##0 (elig[0] == '0) |=> rdata[8:3] == 6'h00)
    else $error("vector index not zero when idle");

  a_vec_best: assert property (beaten[0] == '0 && beaten[1] == '0)
    else $error("vector did not pick best request");

  a_vec_above: assert property (vidx[0] != 6'h00 |->
      elig[0][vidx[0]] && st.ctrl[vidx[0]].prio > st.thr[0])
    else $error("vector request not above threshold");

  a_core_line: assert property (elig[0] != '0 |=> irq_core)
    else $error("core request missing");

  a_pend_low: assert property (bus.rd && bus.addr == OFF_PEND_LO |=>
      rdata == {$past(req_in[31:1]), 1'b0})
    else $error("low pending summary wrong");

  a_pend_high: assert property (bus.rd && bus.addr == OFF_PEND_HI |=>
      rdata[24:0] == $past(req_in[56:32]))
    else $error("high pending summary wrong");

  a_feat_value: assert property (bus.rd && bus.addr == OFF_FEATURES |=>
      rdata == FEATURES_VAL)
    else $error("features value wrong");

  a_stat_sticky: assert property ($rose(st.tgt_req[0]) |-> st.status[0] ##1
      (irq || !$past(st.mask[0])))
    else $error("status or interrupt not raised");

  a_thr1_reserved: assert property (bus.rd && bus.addr == OFF_THR1 |=>
      rdata[31:4] == 28'h0000000)
    else $error("threshold one reserved bits not zero");

  a_vec1_empty: assert property (s_rd_vec1 ##0 (elig[1] == '0) |=> rdata[8:3] == 6'h00)
    else $error("vector one index not zero when idle");

  a_pm_line: assert property (elig[1] != '0 |=> wake_pm)
    else $error("power management request missing");

  a_core_quiet: assert property (elig[0] == '0 |=> !irq_core)
    else $error("core request without eligible source");

  a_vec0_base: assert property (s_rd_vec0 |=> rdata[31:11] == $past(st.base[0]))
    else $error("vector zero base wrong");

  a_thr_store: assert property (s_wr_thr0 |=> st.thr[0] == $past(bus.wdata[3:0]))
    else $error("threshold not stored");

  a_vec1_above: assert property (vidx[1] != 6'h00 |->
      st.ctrl[vidx[1]].prio > st.thr[1] && st.ctrl[vidx[1]].target)
    else $error("vector one request not eligible");

endmodule
`default_nettype wire

/* dv/vecirq_target_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Processor and power-management side: counts each new request assertion
module vecirq_target_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       irq_core,
  input  wire logic       wake_pm,
  output logic      [7:0] core_hits,
  output logic      [7:0] pm_hits
);
  logic core_q;
  logic pm_q;
  always_ff @(posedge clk) begin
    core_q    <= srst ? 1'b0 : irq_core;
    pm_q      <= srst ? 1'b0 : wake_pm;
    core_hits <= srst ? 8'h00 : core_hits + 8'(irq_core & ~core_q);
    pm_hits   <= srst ? 8'h00 : pm_hits + 8'(wake_pm & ~pm_q);
  end
endmodule
`default_nettype wire

/* dv/vectored_irq_threshold_vector_pending_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module vectored_irq_threshold_vector_pending_tb_top;
  import vecirq_pkg::*;
  typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] e;} vecirq_row_t;
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  vecirq_bus_t   bus = '0;
  logic [NREQ:1] req_in = '0;
  logic [31:0]   rdata;
  logic          irq_core;
  logic          wake_pm;
  logic          irq;
  logic [7:0]    core_hits;
  logic [7:0]    pm_hits;
  int            bad_count = 0;
  int            comparisons = 0;
  vecirq_row_t   rows[9] = '{
    '{OFF_THR0, 32'hFFFF_FFF7, 32'h7}, '{OFF_THR1, 32'hA, 32'hA},
    '{OFF_VEC0, 32'hFFFF_FFFF, 32'hFFFF_F800}, '{OFF_VEC1, 32'hE00, 32'h800},
    '{OFF_PEND_LO, 32'hFFFF_FFFF, 32'h0}, '{OFF_PEND_HI, 32'hFFFF_FFFF, 32'h0},
    '{OFF_FEATURES, 32'h0, 32'h0001_0F3F}, '{32'hFFFF_F0F0, 32'h1, 32'h0},
    '{OFF_IRQ_MASK, 32'h3, 32'h3}};

  always #20 clk = ~clk;

  vecirq_top DUT (.clk(clk), .srst(srst), .bus(bus), .req_in(req_in), .rdata(rdata),
                  .irq_core(irq_core), .wake_pm(wake_pm), .irq(irq));
  vecirq_target_model partner (.clk(clk), .srst(srst), .irq_core(irq_core),
                               .wake_pm(wake_pm), .core_hits(core_hits), .pm_hits(pm_hits));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Request control word: enable set, target and priority as given
  task automatic cfg(input int n, input logic [3:0] p, input logic t);
    wr(32'hFFFF_F404 + 32'(4 * (n - 1)), {15'h0, 1'b1, 7'h0, t, 4'h0, p});
  endtask

  initial begin
    #2000000;
    bad_count++;
    conclude();
  end

  initial begin
    tick(20);
    srst <= 1'b0;
    rc(OFF_THR0, 32'h0);
    rc(OFF_VEC1, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    // Back-to-back write then read, no idle cycle
    @(posedge clk);
    bus.addr  <= OFF_THR0;
    bus.wdata <= 32'h5;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, 32'h5);
    // ----------------------------------------
    // Threshold, priority, tie and index
    // ----------------------------------------
    wr(OFF_THR0, 32'h2);
    cfg(3, 4'h4, 1'b0);
    cfg(5, 4'h4, 1'b0);
    cfg(40, 4'h9, 1'b0);
    cfg(56, 4'hB, 1'b1);
    req_in[3] <= 1'b1;
    req_in[5] <= 1'b1;
    tick(2);
    chk({31'h0, irq_core}, 32'h1);
    rc(OFF_VEC0, 32'hFFFF_F800 | (32'd3 << 3));
    rc(OFF_PEND_LO, 32'h0000_0028);
    req_in[40] <= 1'b1;
    tick(2);
    rc(OFF_VEC0, 32'hFFFF_F800 | (32'd40 << 3));
    rc(OFF_PEND_HI, 32'h0000_0100);
    wr(OFF_THR0, 32'h9);
    rc(OFF_VEC0, 32'hFFFF_F800);
    chk({31'h0, irq_core}, 32'h0);
    wr(OFF_THR0, 32'h8);
    rc(OFF_VEC0, 32'hFFFF_F800 | (32'd40 << 3));
    req_in[56] <= 1'b1;
    tick(2);
    chk({31'h0, wake_pm}, 32'h1);
    rc(OFF_VEC1, 32'h800 | (32'd56 << 3));
    // ----------------------------------------
    // Status, mask and clear
    // ----------------------------------------
    tick(1);
    chk({31'h0, irq}, 32'h1);
    rc(OFF_IRQ_STAT, 32'h3);
    chk({24'h0, core_hits}, 32'h2);
    chk({24'h0, pm_hits}, 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    req_in <= '0;
    tick(2);
    chk({30'h0, irq_core, wake_pm}, 32'h0);
    wr(OFF_IRQ_STAT, 32'h3);
    rc(OFF_IRQ_STAT, 32'h0);
    wr(OFF_IRQ_MASK, 32'h3);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    // Top priority against top threshold stays quiet
    wr(OFF_THR0, 32'hF);
    cfg(40, 4'hF, 1'b0);
    req_in[40] <= 1'b1;
    tick(2);
    rc(OFF_VEC0, 32'hFFFF_F800);
    chk({31'h0, irq_core}, 32'h0);
    // ----------------------------------------
    // Reset in mid-run
    // ----------------------------------------
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    rc(OFF_THR1, 32'h0);
    rc(OFF_VEC0, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
